// file: logic/io_data_buffer_control.sv
// Data buffer control: Wishbone registers, timing line, lane steering, 8-word buffer.
// Assumes one clock, synchronous reset, and an asynchronous reset-I/O pin.
`timescale 1ns/1ps

// ============================================================================
// Buffer store: parameterised FIFO, power-of-two depth
module buf_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Filling side
  input  wire logic                       in_valid_i,
  input  wire logic [W-1:0]               in_data_i,
  output      logic                       in_ready_o,
  // Draining side
  output      logic                       out_valid_o,
  input  wire logic                       out_ready_i,
  output      logic [W-1:0]               out_data_o,
  // Fill level
  output      logic [$clog2(DEPTH):0]     level_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             level;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        push;
  logic        pop;

  // Full and empty from the level
  assign in_ready_o  = (s_r.level != (AW+1)'(DEPTH));
  assign out_valid_o = (s_r.level != '0);
  assign out_data_o  = s_r.mem[s_r.rp];
  assign level_o     = s_r.level;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and level update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.level = s_r.level + 1'b1;
    end else if (pop && !push) begin
      s_nxt.level = s_r.level - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ============================================================================
// Top: buffer control
// Operation
// [R01] Four-bit occupancy counter tracks empty buffer locations.
// [R02] Occupancy counts up on fetch cycle, down on store cycle, each on its clock.
// [R03] Room flag in data out: two free words narrow, four free words wide.
// [R04] At most one source lane select during fetch; it marks least significant byte.
// [R05] One lane A steer at a time; one lane B steer at a time.
// [R06] Each fetch cycle strobes buffer output into the K register.
// [R07] One timing line runs both cycles; sensor gives fetch clock, mid tap store clock.
// [R08] Separate latches show fetch cycle and store cycle.
// [R09] Order out clears both pending request latches.
// [R10] Each buffer lane stores a presence bit with its byte.
// [R11] Modifiers set on data out or data in above three; other path below four.
// [R12] One clear signal resets all presence modifiers together.
// [R13] Narrow data out clears J presence bit per byte moved; also clears J full.
// [R14] Count-below-four flag when all count bits above the low two are zero.
// [R15] Zero count flag; latched into flag one at FM21/FM24, flag two at FM22.
// [R16] In data in, fetch cycle starts only with fetch permission set.
// [R17] At most one destination lane select during fetch, least significant K byte.
// [R18] Fetch and store cycles never overlap; requests wait for the line.
// [R19] Reset-I/O clears occupancy counter, request latches and modifiers.
module io_data_buffer_control (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output      logic [31:0]          wb_dat_o,
  output      logic                 wb_ack_o,
  // Reset-I/O pin
  input  wire logic                 io_reset_input_i,
  // Buffer cycle view
  output      io_buf_pkg::lane_sel_t lanes_o,
  output      logic                 read_cycle_o,
  output      logic                 write_cycle_o,
  output      logic                 buffer_output_strobe_o,
  output      logic                 buffer_fetch_clock_o,
  output      logic                 buffer_store_clock_o,
  output      logic [3:0]           j_presence_clear_o,
  // Count and space flags
  output      logic                 room_available_o,
  output      logic [3:0]           occupancy_counter_o,
  output      logic                 count_below_four_o,
  output      logic                 count_is_zero_o,
  output      logic                 zero_count_flag_one_o,
  output      logic                 zero_count_flag_two_o
);
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdat;
    logic                  wide;
    logic                  dout;
    logic                  din;
    logic                  permit;
    logic [15:0]           bcount;
    logic [31:0]           jdata;
    logic [3:0]            jpres;
    logic                  jfull;
    logic [31:0]           kdata;
    logic [3:0]            kpres;
    logic                  kfull;
    logic [1:0]            kptr;
    logic [3:0]            mods;    // D, C, B, A
    logic                  mod_b2;
    logic                  fetch_req;
    logic                  store_req;
    logic                  rd_cyc;
    logic                  wr_cyc;
    logic [3:0]            tr_cnt;
    io_buf_pkg::lane_sel_t lanes;
    logic                  ostrb;
    logic                  fclk;
    logic                  sclk;
    logic [3:0]            jclr;
    logic [3:0]            occ;
    logic                  room;
    logic                  below4;
    logic                  zero;
    logic                  zf1;
    logic                  zf2;
    logic [2:0]            sy;
    logic                  io_lvl;
  } state_t;

  state_t                s_r;
  state_t                s_nxt;
  io_buf_pkg::buf_word_t push_word;
  io_buf_pkg::buf_word_t pop_word;
  logic                  push_valid;
  logic                  push_ready;
  logic                  pop_valid;
  logic                  pop_take;
  logic [3:0]            level;
  logic [3:0]            jsel;
  logic [3:0]            eff_mods;

  // Lowest present J byte and effective lane modifiers
  assign jsel     = s_r.jpres & 4'(~s_r.jpres + 4'h1);
  assign eff_mods = {s_r.mods[3:2], s_r.mods[1] & s_r.mod_b2, s_r.mods[0]};

  // Store word; narrow mode moves one byte into lane A
  always_comb begin
    push_word = '0;
    if (s_r.wide) begin
      push_word.data = s_r.jdata;
      push_word.pres = s_r.jpres & eff_mods;  // [R10]
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (jsel[i]) begin
          push_word.data[7:0] = s_r.jdata[8*i +: 8];
        end
      end
      push_word.pres = {3'b000, (|jsel) & eff_mods[0]};  // [R10]
    end
  end

  assign push_valid = s_r.wr_cyc && (s_r.tr_cnt == io_buf_pkg::TR_STORE_CYC);  // [R07]
  assign pop_take   = s_r.rd_cyc && (s_r.tr_cnt == io_buf_pkg::TR_SENSOR_CYC);  // [R07]

  // Buffer storage
  buf_fifo #(
    .W     ($bits(io_buf_pkg::buf_word_t)),
    .DEPTH (io_buf_pkg::BUF_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid),
    .in_data_i   (push_word),
    .in_ready_o  (push_ready),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_take),
    .out_data_o  (pop_word),
    .level_o     (level)
  );

  // Next state of the whole block
  always_comb begin
    logic [31:0] m;
    logic        wr;
    logic        rd;
    logic        iorst;
    logic        ord_out;
    logic        st_set;
    logic        ft_set;
    logic        mload;
    logic        mclr;
    logic [3:0]  free;
    m       = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wr      = wb_cyc_i && wb_stb_i && wb_we_i && !s_r.ack;
    rd      = wb_cyc_i && wb_stb_i && !wb_we_i && !s_r.ack;
    ord_out = 1'b0;
    st_set  = 1'b0;
    ft_set  = 1'b0;
    mload   = 1'b0;
    mclr    = 1'b0;
    free    = 4'(io_buf_pkg::BUF_DEPTH) - level;
    s_nxt   = s_r;
    s_nxt.ack   = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ostrb = 1'b0;
    s_nxt.fclk  = 1'b0;
    s_nxt.sclk  = 1'b0;
    s_nxt.jclr  = 4'h0;

    // Reset-I/O pin: three stages, moves when last two agree
    s_nxt.sy = {s_r.sy[1:0], io_reset_input_i};
    if (s_r.sy[1] == s_r.sy[2]) begin
      s_nxt.io_lvl = s_r.sy[2];
    end

    // Register writes
    if (wr) begin
      unique case (wb_adr_i)
        io_buf_pkg::OFF_CTRL: begin
          s_nxt.wide   = m[io_buf_pkg::CTRL_WIDE] ? wb_dat_i[io_buf_pkg::CTRL_WIDE] : s_r.wide;
          s_nxt.dout   = m[io_buf_pkg::CTRL_DOUT] ? wb_dat_i[io_buf_pkg::CTRL_DOUT] : s_r.dout;
          s_nxt.din    = m[io_buf_pkg::CTRL_DIN] ? wb_dat_i[io_buf_pkg::CTRL_DIN] : s_r.din;
          s_nxt.permit = m[io_buf_pkg::CTRL_PERMIT] ? wb_dat_i[io_buf_pkg::CTRL_PERMIT]
                                                    : s_r.permit;
          ord_out = m[io_buf_pkg::CTRL_ORDOUT] & wb_dat_i[io_buf_pkg::CTRL_ORDOUT];
          st_set  = m[io_buf_pkg::CTRL_STORE] & wb_dat_i[io_buf_pkg::CTRL_STORE];
          ft_set  = m[io_buf_pkg::CTRL_FETCH] & wb_dat_i[io_buf_pkg::CTRL_FETCH];
          mload   = m[io_buf_pkg::CTRL_MODLOAD] & wb_dat_i[io_buf_pkg::CTRL_MODLOAD];
          mclr    = m[io_buf_pkg::CTRL_MODCLEAR] & wb_dat_i[io_buf_pkg::CTRL_MODCLEAR];
        end
        io_buf_pkg::OFF_COUNT: begin
          s_nxt.bcount = (s_r.bcount & ~m[15:0]) | (wb_dat_i[15:0] & m[15:0]);
        end
        io_buf_pkg::OFF_PHASE: begin
          // Zero count caught at the phase named by software
          if (m[io_buf_pkg::PH_FM21] & (wb_dat_i[io_buf_pkg::PH_FM21]
                                        | wb_dat_i[io_buf_pkg::PH_FM24])) begin
            s_nxt.zf1 = s_r.zero;  // [R15]
          end
          if (m[io_buf_pkg::PH_FM22] & wb_dat_i[io_buf_pkg::PH_FM22]) begin
            s_nxt.zf2 = s_r.zero;  // [R15]
          end
        end
        io_buf_pkg::OFF_JDATA: begin
          // Refused while the J register still holds bytes
          if (!s_r.jfull) begin
            s_nxt.jdata = wb_dat_i;
            s_nxt.jpres = wb_sel_i;
            s_nxt.jfull = |wb_sel_i;
            st_set      = |wb_sel_i;
          end
        end
        io_buf_pkg::OFF_KDATA: begin
          // Any write releases the K register
          s_nxt.kpres = 4'h0;
          s_nxt.kfull = 1'b0;
          s_nxt.kptr  = 2'b00;
        end
        default: begin
        end
      endcase
    end
    iorst = s_r.io_lvl
          | (wr && (wb_adr_i == io_buf_pkg::OFF_CTRL) && m[io_buf_pkg::CTRL_IORESET]
             && wb_dat_i[io_buf_pkg::CTRL_IORESET]);

    // Timing line: one cycle at a time, store before fetch
    if (s_r.rd_cyc || s_r.wr_cyc) begin
      s_nxt.tr_cnt = s_r.tr_cnt + 4'h1;
      if (push_valid) begin
        s_nxt.sclk = 1'b1;  // [R07]
        s_nxt.occ  = s_r.occ - 4'h1;  // [R02]
        if (s_r.wide) begin
          s_nxt.jclr  = s_r.jpres;
          s_nxt.jpres = 4'h0;
          s_nxt.jfull = 1'b0;
        end else begin
          s_nxt.jclr  = jsel;  // [R13]
          s_nxt.jpres = s_r.jpres & ~jsel;  // [R13]
          s_nxt.jfull = |(s_r.jpres & ~jsel);  // [R13]
          st_set      = st_set | (|(s_r.jpres & ~jsel));
        end
      end
      if (pop_take) begin
        s_nxt.ostrb = 1'b1;  // [R06]
        s_nxt.fclk  = 1'b1;  // [R07]
        s_nxt.occ   = s_r.occ + 4'h1;  // [R02]
        if (s_r.wide) begin
          s_nxt.kdata = pop_word.data;
          s_nxt.kpres = pop_word.pres;
          s_nxt.kfull = 1'b1;
        end else begin
          s_nxt.kdata[8*s_r.kptr +: 8] = pop_word.data[7:0];
          s_nxt.kpres[s_r.kptr]        = pop_word.pres[0];
          s_nxt.kptr                   = s_r.kptr + 2'b01;
          s_nxt.kfull                  = (s_r.kptr == 2'b11);
        end
      end
      if (s_r.tr_cnt == io_buf_pkg::TR_LEN_CYC) begin
        s_nxt.rd_cyc = 1'b0;  // [R08]
        s_nxt.wr_cyc = 1'b0;  // [R08]
        s_nxt.tr_cnt = 4'h0;
        s_nxt.lanes  = '0;
      end
    end else if (s_r.store_req && s_r.jfull && push_ready) begin  // [R18]
      s_nxt.wr_cyc        = 1'b1;  // [R08]
      s_nxt.store_req     = 1'b0;
      s_nxt.tr_cnt        = 4'h1;
      s_nxt.lanes.steer_a = s_r.wide ? 4'b0001 : jsel;  // [R05]
      s_nxt.lanes.steer_b = s_r.wide ? 2'b01 : 2'b00;  // [R05]
    end else if (s_r.fetch_req && pop_valid && !s_r.kfull
                 && (!s_r.din || s_r.permit)) begin  // [R16] [R18]
      s_nxt.rd_cyc    = 1'b1;  // [R08]
      s_nxt.fetch_req = 1'b0;
      s_nxt.tr_cnt    = 4'h1;
      s_nxt.lanes.src = 4'b0001;  // [R04]
      s_nxt.lanes.dst = s_r.wide ? 4'b0001 : 4'(4'b0001 << s_r.kptr);  // [R17]
    end

    // Request latches: sets win over clears
    if (ord_out || iorst) begin
      s_nxt.store_req = 1'b0;  // [R09] [R19]
      s_nxt.fetch_req = 1'b0;  // [R09] [R19]
    end
    if (st_set) begin
      s_nxt.store_req = 1'b1;
    end
    if (ft_set) begin
      s_nxt.fetch_req = 1'b1;
    end

    // Presence modifiers
    if (mclr || iorst) begin
      s_nxt.mods   = 4'h0;  // [R12] [R19]
      s_nxt.mod_b2 = 1'b0;  // [R12]
    end
    if (mload && (s_nxt.dout || (s_nxt.din && !s_r.below4))) begin
      s_nxt.mods   = 4'hF;  // [R11]
      s_nxt.mod_b2 = 1'b1;  // [R11]
    end else if (mload && s_nxt.din && s_r.below4) begin
      s_nxt.mods   = {1'b0, s_r.bcount[1:0] == 2'b11, s_r.bcount[1], |s_r.bcount[1:0]};  // [R11]
      s_nxt.mod_b2 = s_r.bcount[1];  // [R11]
    end
    if (iorst) begin
      s_nxt.occ = 4'h0;  // [R19] [R01]
    end

    // Registered flags
    s_nxt.below4 = (s_nxt.bcount[15:2] == 14'h0000);  // [R14]
    s_nxt.zero   = (s_nxt.bcount == 16'h0000);  // [R15]
    s_nxt.room   = s_r.dout && (free >= (s_r.wide ? 4'h4 : 4'h2));  // [R03]

    // Read data
    s_nxt.rdat = io_buf_pkg::WORD_RST;
    if (rd) begin
      unique case (wb_adr_i)
        io_buf_pkg::OFF_CTRL:   s_nxt.rdat = {28'h000_0000, s_r.permit, s_r.din, s_r.dout,
                                              s_r.wide};
        io_buf_pkg::OFF_COUNT:  s_nxt.rdat = {16'h0000, s_r.bcount};
        io_buf_pkg::OFF_JDATA:  s_nxt.rdat = s_r.jdata;
        io_buf_pkg::OFF_KDATA:  s_nxt.rdat = s_r.kdata;
        io_buf_pkg::OFF_STATUS: s_nxt.rdat = {1'b0, s_r.mods, level, s_r.zf2, s_r.zf1,
                                              s_r.zero, s_r.below4, s_r.kfull, s_r.kpres,
                                              s_r.jpres, s_r.jfull, s_r.store_req,
                                              s_r.fetch_req, s_r.wr_cyc, s_r.rd_cyc,
                                              s_r.room, s_r.occ};  // [R01]
        default:                s_nxt.rdat = io_buf_pkg::WORD_RST;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r        <= '0;
      s_r.bcount <= io_buf_pkg::COUNT_RST;
      s_r.zero   <= 1'b1;
      s_r.below4 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o               = s_r.rdat;
  assign wb_ack_o               = s_r.ack;
  assign lanes_o                = s_r.lanes;
  assign read_cycle_o           = s_r.rd_cyc;
  assign write_cycle_o          = s_r.wr_cyc;
  assign buffer_output_strobe_o = s_r.ostrb;
  assign buffer_fetch_clock_o   = s_r.fclk;
  assign buffer_store_clock_o   = s_r.sclk;
  assign j_presence_clear_o     = s_r.jclr;
  assign room_available_o       = s_r.room;
  assign occupancy_counter_o    = s_r.occ;
  assign count_below_four_o     = s_r.below4;
  assign count_is_zero_o        = s_r.zero;
  assign zero_count_flag_one_o  = s_r.zf1;
  assign zero_count_flag_two_o  = s_r.zf2;
endmodule

// file: pkg/io_buf_pkg.sv
// Constants, register map and carrier types for the I/O data buffer control block.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register port.
package io_buf_pkg;

  // ==========================================================================
  // Timing of the buffer timing line
  localparam int CLK_NS          = 100;
  localparam int TR_STORE_TAP_NS = 150;  // Store clock tap
  localparam int TR_SENSOR_NS    = 290;  // Sensor output, fetch clock
  localparam int TR_LEN_NS       = 300;  // Whole line
  localparam logic [3:0] TR_STORE_CYC  = 4'((TR_STORE_TAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] TR_SENSOR_CYC = 4'((TR_SENSOR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] TR_LEN_CYC    = 4'((TR_LEN_NS + CLK_NS - 1) / CLK_NS);

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_PHASE  = 8'h08;
  localparam logic [7:0] OFF_JDATA  = 8'h0C;
  localparam logic [7:0] OFF_KDATA  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_WIDE     = 0;
  localparam int CTRL_DOUT     = 1;
  localparam int CTRL_DIN      = 2;
  localparam int CTRL_PERMIT   = 3;
  localparam int CTRL_ORDOUT   = 8;
  localparam int CTRL_STORE    = 9;
  localparam int CTRL_FETCH    = 10;
  localparam int CTRL_MODLOAD  = 11;
  localparam int CTRL_MODCLEAR = 12;
  localparam int CTRL_IORESET  = 13;
  // Phase register fields
  localparam int PH_FM21 = 0;
  localparam int PH_FM22 = 1;
  localparam int PH_FM24 = 2;

  // ==========================================================================
  // Reset values and depths
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam int          BUF_DEPTH = 8;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [3:0]  pres;
    logic [31:0] data;
  } buf_word_t;

  typedef struct packed {
    logic [3:0] src;      // Buffer lane holding least significant byte
    logic [3:0] dst;      // K lane receiving least significant byte
    logic [3:0] steer_a;  // J byte into buffer lane A
    logic [1:0] steer_b;  // J byte B or D into buffer lane B
  } lane_sel_t;

endpackage

// file: tb/io_buf_chk.sv
// Checker of timing relations on the buffer control top ports.
// Assumes one clock clk_i and synchronous active-high reset rst_i.
`timescale 1ns/1ps
module io_buf_chk (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // Observed ports
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire io_buf_pkg::lane_sel_t lanes_o,
  input wire logic                  read_cycle_o,
  input wire logic                  write_cycle_o,
  input wire logic                  buffer_output_strobe_o,
  input wire logic                  buffer_fetch_clock_o,
  input wire logic                  buffer_store_clock_o,
  input wire logic [3:0]            occupancy_counter_o,
  input wire logic                  count_below_four_o,
  input wire logic                  count_is_zero_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Bus answer
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // ==========================================================================
  // Buffer cycles and lanes
  no_overlap_a: assert property (!(read_cycle_o && write_cycle_o))
    else $error("fetch and store overlap");
  lane_onehot_a: assert property ($onehot0(lanes_o.src) && $onehot0(lanes_o.dst))
    else $error("two lanes selected");
  steer_onehot_a: assert property ($onehot0(lanes_o.steer_a) && $onehot0(lanes_o.steer_b))
    else $error("two steers active");
  store_len_a: assert property ($rose(write_cycle_o) |-> write_cycle_o[*3] ##1 !write_cycle_o)
    else $error("store cycle length wrong");
  store_tap_a: assert property ($rose(write_cycle_o) |-> ##2 buffer_store_clock_o)
    else $error("store clock off tap");
  fetch_end_a: assert property ($fell(read_cycle_o) |-> buffer_output_strobe_o)
    else $error("fetch ended unstrobed");
  occ_up_a: assert property (buffer_output_strobe_o |-> buffer_fetch_clock_o
    && occupancy_counter_o == $past(occupancy_counter_o) + 4'h1)
    else $error("occupancy not up on fetch");
  occ_down_a: assert property (buffer_store_clock_o
    |-> occupancy_counter_o == $past(occupancy_counter_o) - 4'h1)
    else $error("occupancy not down on store");
  zero_below_a: assert property (count_is_zero_o |-> count_below_four_o)
    else $error("zero without below four");
  // Main scenarios
  store_c: cover property ($rose(write_cycle_o));
  fetch_c: cover property ($rose(read_cycle_o));
  ack_c: cover property (wb_ack_o);
endmodule

bind io_data_buffer_control io_buf_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .lanes_o, .read_cycle_o, .write_cycle_o, .buffer_output_strobe_o, .buffer_fetch_clock_o,
  .buffer_store_clock_o, .occupancy_counter_o, .count_below_four_o, .count_is_zero_o);

// file: tb/io_data_buffer_control_test.sv
// Testbench: register-driven tests of buffer cycles, counts and flags.
// Assumes the register map and timing of the io_buf_pkg package.
`timescale 1ns/1ps
module io_data_buffer_control_test;
  logic                  clk_i, rst_i, cyc, stb, we, io_rst, ack, rc, wc, sb, fc, sc;
  logic                  room, b4, zr, zf1, zf2;
  logic [7:0]            adr, stores, fetches;
  logic [3:0]            sel, jclr, occ;
  logic [31:0]           wdat, dat_o, rdat, st;
  io_buf_pkg::lane_sel_t lanes;
  int                    err_count, total_checks;

  io_data_buffer_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .io_reset_input_i(io_rst), .lanes_o(lanes), .read_cycle_o(rc),
    .write_cycle_o(wc), .buffer_output_strobe_o(sb), .buffer_fetch_clock_o(fc),
    .buffer_store_clock_o(sc), .j_presence_clear_o(jclr), .room_available_o(room),
    .occupancy_counter_o(occ), .count_below_four_o(b4), .count_is_zero_o(zr),
    .zero_count_flag_one_o(zf1), .zero_count_flag_two_o(zf2));
  io_far_side_model far_u (.clk_i(clk_i), .rst_i(rst_i), .store_clk_i(sc),
    .fetch_strobe_i(sb), .stores_o(stores), .fetches_o(fetches));

  // ==========================================================================
  // Bus tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(io_buf_pkg::OFF_CTRL, d);
  endtask
  task automatic rd_st;
    wb(1'b0, io_buf_pkg::OFF_STATUS, 32'h0000_0000, 4'hF);
    st = rdat;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // Read status until the masked busy bits clear, bounded
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd_st;
      n++;
    end while ((st & m) !== 32'h0000_0000 && n < 60);
    chk("busy bits", 32'h0000_0000, st & m);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done;
  end

  // ==========================================================================
  // Tests
  initial begin
    {rst_i, cyc, stb, we, io_rst, adr, sel, wdat} = {1'b1, 48'h0};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_st;
    chk("status after reset", 32'h0018_0000, st);
    wr(8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0000_0000, 4'hF);
    chk("unmapped read", 32'h0000_0000, rdat);
    $display("test reset done");
    // Narrow data out: one J word becomes four byte stores
    ctl(32'h0000_0802);
    wr(io_buf_pkg::OFF_JDATA, 32'h4433_2211);
    poll(32'h0000_0340);
    chk("occupancy", 32'h0000_000C, 32'(st[3:0]));
    chk("fifo level", 32'h0000_0004, 32'(st[26:23]));
    chk("j presence", 32'h0000_0000, 32'(st[13:10]));
    chk("stores", 32'h0000_0004, 32'(stores));
    // Four fetches fill K and bring the count back
    repeat (4) begin
      ctl(32'h0000_0402);
      poll(32'h0000_00A0);
    end
    chk("occupancy", 32'h0000_0000, 32'(st[3:0]));
    chk("k full", 32'h0000_0001, 32'(st[18]));
    wb(1'b0, io_buf_pkg::OFF_KDATA, 32'h0000_0000, 4'hF);
    chk("k data", 32'h4433_2211, rdat);
    chk("fetches", 32'h0000_0004, 32'(fetches));
    $display("test narrow done");
    // Wide mode: five words leave three free
    wr(io_buf_pkg::OFF_KDATA, 32'h0000_0000);
    ctl(32'h0000_0003);
    repeat (5) begin
      wr(io_buf_pkg::OFF_JDATA, 32'h8765_4321);
      poll(32'h0000_0340);
    end
    chk("room wide", 32'h0000_0000, 32'(st[4]));
    chk("occupancy", 32'h0000_000B, 32'(st[3:0]));
    ctl(32'h0000_0002);
    rd_st;
    chk("room narrow", 32'h0000_0001, 32'(st[4]));
    $display("test room done");
    // Data in: fetch waits for permission; order out clears it
    ctl(32'h0000_0404);
    rd_st;
    chk("fetch pending", 32'h0000_0001, 32'(st[7]));
    ctl(32'h0000_0104);
    rd_st;
    chk("fetch cleared", 32'h0000_0000, 32'(st[7]));
    ctl(32'h0000_040C);
    poll(32'h0000_00A0);
    chk("occupancy", 32'h0000_000C, 32'(st[3:0]));
    $display("test requests done");
    // Byte count flags and modifier paths
    wr(io_buf_pkg::OFF_COUNT, 32'h0000_0004);
    rd_st;
    chk("count flags", 32'h0000_0000, 32'(st[20:19]));
    wr(io_buf_pkg::OFF_COUNT, 32'h0000_0003);
    ctl(32'h0000_0804);
    rd_st;
    chk("count flags", 32'h0000_0001, 32'(st[20:19]));
    chk("modifiers", 32'h0000_0007, 32'(st[30:27]));
    wr(io_buf_pkg::OFF_COUNT, 32'h0000_0000);
    wr(io_buf_pkg::OFF_PHASE, 32'h0000_0002);
    rd_st;
    chk("zero flags", 32'h0000_000B, 32'(st[22:19]));
    wb(1'b1, io_buf_pkg::OFF_PHASE, 32'h0000_0001, 4'h1);
    rd_st;
    chk("zero flags", 32'h0000_000F, 32'(st[22:19]));
    ctl(32'h0000_1004);
    rd_st;
    chk("modifiers", 32'h0000_0000, 32'(st[30:27]));
    $display("test counts done");
    // Reset-I/O pin clears occupancy and modifiers
    ctl(32'h0000_0802);
    io_rst <= 1'b1;
    repeat (6) @(posedge clk_i);
    io_rst <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd_st;
    chk("occ and modifiers", 32'h0000_0000, 32'({st[30:27], st[3:0]}));
    $display("test io reset done");
    test_done;
  end
endmodule

// file: tb/io_far_side_model.sv
// Far side model: counts words stored into and fetched from the buffer.
// Assumes the block's store clock and output strobe are one-cycle pulses.
`timescale 1ns/1ps
module io_far_side_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Buffer pulses
  input  wire logic       store_clk_i,
  input  wire logic       fetch_strobe_i,
  // Tallies
  output      logic [7:0] stores_o,
  output      logic [7:0] fetches_o
);
  // Tally each pulse seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stores_o  <= 8'h00;
      fetches_o <= 8'h00;
    end else begin
      stores_o  <= stores_o + {7'h00, store_clk_i};
      fetches_o <= fetches_o + {7'h00, fetch_strobe_i};
    end
  end
endmodule
